// [rtl/led_bank_consts.vh]
/*
  Shared constants of the LED bank dimming control: register addresses, field positions,
  reset values and state codes.
  Assumes it is included by its bare name from every design file that needs it.
*/
`ifndef LED_BANK_CONSTS_VH
`define LED_BANK_CONSTS_VH

// ==========================================================================
// Register addresses
// ==========================================================================
`define ADDR_GENERAL 8'h10
`define ADDR_CONFIG 8'h20
`define ADDR_CHA 8'hA0
`define ADDR_CH3 8'h30
`define ADDR_CH4 8'h40
`define ADDR_CH5 8'h50
`define ADDR_CH6 8'h60

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_GENERAL 8'h00
`define RST_CONFIG 8'h00
`define RST_CHANNEL 8'hFF
`define RD_UNMAPPED 8'h00

// ==========================================================================
// Field positions
// ==========================================================================
// Pin mode select in the general register.
`define GEN_PWM_MODE_BIT 7
// Bank enables in the general register: group A, then LED3 to LED6.
`define GEN_EN_A_BIT 0
`define GEN_EN_LO 1
`define GEN_EN_HI 4
// Group A join bits for LED3 to LED6 in the config register.
`define CFG_JOIN_LO 0
`define CFG_JOIN_HI 3
// Dimming code field of a channel register.
`define CODE_HI 5
`define CODE_LO 0

// ==========================================================================
// Widths and state codes
// ==========================================================================
`define LEVEL_W 17
// Full-scale level, also the level shown while the lookup is in reset.
`define LEVEL_FULL 17'h186A0
`define PUMP_1X 1'b0
`define PUMP_15X 1'b1

`endif

// [rtl/led_level_lut.v]
/*
  Brightness lookup for one LED: maps a 6-bit dimming code to the sink current as a
  fraction of full scale, in thousandths of a percent, from a register.
  Assumes a single clock, the synchronised reset copy and the shared clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "led_bank_consts.vh"

module led_level_lut #(
  parameter CODE_W = 6
) (
  // Clock and reset.
  input wire clk,
  input wire rst_sync_b,
  input wire ce,
  // Code in, level out.
  input wire [CODE_W-1:0] dimming_code_bits,
  output reg [`LEVEL_W-1:0] level_q
);

  reg [`LEVEL_W-1:0] level_d; // Looked-up level.

  // ==========================================================================
  // Exponential table; rises strictly with the code.
  // ==========================================================================
  // Constant table; the spacing is roughly 8% per step at the top end.
  always @* begin
    case (dimming_code_bits)
      6'h00: level_d = 17'h0007D;
      6'h01: level_d = 17'h000BC;
      6'h02: level_d = 17'h000F9;
      6'h03: level_d = 17'h00138;
      6'h04: level_d = 17'h00176;
      6'h05: level_d = 17'h001B6;
      6'h06: level_d = 17'h001F3;
      6'h07: level_d = 17'h00230;
      6'h08: level_d = 17'h0026E;
      6'h09: level_d = 17'h002B4;
      6'h0A: level_d = 17'h002EE;
      6'h0B: level_d = 17'h0032A;
      6'h0C: level_d = 17'h0036B;
      6'h0D: level_d = 17'h003AA;
      6'h0E: level_d = 17'h003EC;
      6'h0F: level_d = 17'h00464;
      6'h10: level_d = 17'h004E2;
      6'h11: level_d = 17'h0055F;
      6'h12: level_d = 17'h005DB;
      6'h13: level_d = 17'h00659;
      6'h14: level_d = 17'h006D6;
      6'h15: level_d = 17'h00759;
      6'h16: level_d = 17'h0080F;
      6'h17: level_d = 17'h008C9;
      6'h18: level_d = 17'h00986;
      6'h19: level_d = 17'h00A7F;
      6'h1A: level_d = 17'h00B7B;
      6'h1B: level_d = 17'h00C72;
      6'h1C: level_d = 17'h00DEA;
      6'h1D: level_d = 17'h00F60;
      6'h1E: level_d = 17'h010D6;
      6'h1F: level_d = 17'h012CD;
      6'h20: level_d = 17'h014C2;
      6'h21: level_d = 17'h01730;
      6'h22: level_d = 17'h019A5;
      6'h23: level_d = 17'h01C91;
      6'h24: level_d = 17'h01F7B;
      6'h25: level_d = 17'h022EA;
      6'h26: level_d = 17'h02694;
      6'h27: level_d = 17'h02A7A;
      6'h28: level_d = 17'h02EE5;
      6'h29: level_d = 17'h033C5;
      6'h2A: level_d = 17'h0391A;
      6'h2B: level_d = 17'h03EFC;
      6'h2C: level_d = 17'h045D9;
      6'h2D: level_d = 17'h04DA3;
      6'h2E: level_d = 17'h05669;
      6'h2F: level_d = 17'h0602D;
      6'h30: level_d = 17'h06AF0;
      6'h31: level_d = 17'h076A5;
      6'h32: level_d = 17'h08357;
      6'h33: level_d = 17'h09104;
      6'h34: level_d = 17'h09FA9;
      6'h35: level_d = 17'h0AF4B;
      6'h36: level_d = 17'h0BFE4;
      6'h37: level_d = 17'h0D178;
      6'h38: level_d = 17'h0E407;
      6'h39: level_d = 17'h0F792;
      6'h3A: level_d = 17'h10C11;
      6'h3B: level_d = 17'h1218A;
      6'h3C: level_d = 17'h13802;
      6'h3D: level_d = 17'h14F71;
      6'h3E: level_d = 17'h168D5;
      default: level_d = 17'h186A0;
    endcase
  end

  // The level is registered so that the output is glitch free.
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      level_q <= `LEVEL_FULL;
    end else if (ce) begin
      level_q <= level_d;
    end
  end

endmodule // led_level_lut
`default_nettype wire

// [rtl/led_bank_ctrl.v]
/*
  LED bank dimming control: shared enable/dimming pin handling, the register file written
  by the serial front end, bank grouping, per-LED brightness and charge pump mode choice.
  Assumes the serial front end runs on clk and presents one-cycle write and read strobes;
  the shared pin and the analog comparator flags arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "led_bank_consts.vh"

module led_bank_ctrl #(
  parameter NUM_LED = 6,
  parameter CODE_W = 6
) (
  // Clock, reset and clock enable.
  input wire clk,
  input wire rst_b,
  input wire ce,
  // Shared enable / dimming pin.
  input wire en_pin,
  // Register port from the serial front end.
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  output reg serial_enable_q,
  // Analog comparator flags, one per LED.
  input wire [NUM_LED-1:0] reg_lost,
  input wire [NUM_LED-1:0] cathode_above,
  // LED drive and pump outputs.
  output reg [NUM_LED-1:0] led_on_q,
  output reg [NUM_LED*CODE_W-1:0] led_code_q,
  output wire [NUM_LED*`LEVEL_W-1:0] led_level,
  output reg pump_mode_q
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  reg [1:0] rst_pipe_q; // Two-stage release of the asynchronous reset.
  wire rst_sync_b = rst_pipe_q[1];

  // Release through two flops so every flop leaves reset on the same edge.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  reg [2:0] pin_sync_q; // Three flops on the shared pin.
  reg pin_q; // Filtered pin level.
  reg [NUM_LED-1:0] lost_s1_q, lost_s2_q, lost_s3_q, lost_q; // Regulation-lost chain.
  reg [NUM_LED-1:0] abv_s1_q, abv_s2_q, abv_s3_q, abv_q; // Cathode-above chain.
  wire pin_d;
  wire [NUM_LED-1:0] lost_d;
  wire [NUM_LED-1:0] abv_d;

  // A level counts only once the second and third stage agree; otherwise hold.
  assign pin_d = (pin_sync_q[1] & pin_sync_q[2]) | (pin_q & (pin_sync_q[1] | pin_sync_q[2]));
  assign lost_d = (lost_s2_q & lost_s3_q) | (lost_q & (lost_s2_q | lost_s3_q));
  assign abv_d = (abv_s2_q & abv_s3_q) | (abv_q & (abv_s2_q | abv_s3_q));

  // The first stage feeds only the second; all decisions use the filtered copies.
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_sync_q <= 3'h0;
      pin_q <= 1'b0;
      lost_s1_q <= {NUM_LED{1'b0}};
      lost_s2_q <= {NUM_LED{1'b0}};
      lost_s3_q <= {NUM_LED{1'b0}};
      lost_q <= {NUM_LED{1'b0}};
      abv_s1_q <= {NUM_LED{1'b0}};
      abv_s2_q <= {NUM_LED{1'b0}};
      abv_s3_q <= {NUM_LED{1'b0}};
      abv_q <= {NUM_LED{1'b0}};
    end else if (ce) begin
      pin_sync_q <= {pin_sync_q[1:0], en_pin};
      pin_q <= pin_d;
      lost_s1_q <= reg_lost;
      lost_s2_q <= lost_s1_q;
      lost_s3_q <= lost_s2_q;
      lost_q <= lost_d;
      abv_s1_q <= cathode_above;
      abv_s2_q <= abv_s1_q;
      abv_s3_q <= abv_s2_q;
      abv_q <= abv_d;
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  reg [7:0] general_q; // Mode bit and bank enables.
  reg [7:0] config_q; // Group A join bits.
  reg [7:0] cha_q, ch3_q, ch4_q, ch5_q, ch6_q; // Channel brightness registers.
  wire pwm_mode = general_q[`GEN_PWM_MODE_BIT];
  // Enable mode with the pin low holds the whole device in its default state.
  wire dev_clear = !pwm_mode && !pin_q;

  // Writes are taken whenever the device is enabled, whatever the LEDs do.
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      general_q <= `RST_GENERAL;
      config_q <= `RST_CONFIG;
      cha_q <= `RST_CHANNEL;
      ch3_q <= `RST_CHANNEL;
      ch4_q <= `RST_CHANNEL;
      ch5_q <= `RST_CHANNEL;
      ch6_q <= `RST_CHANNEL;
    end else if (ce) begin
      if (dev_clear) begin
        // Defaults come back; a dimming-mode low never reaches here.
        general_q <= `RST_GENERAL;
        config_q <= `RST_CONFIG;
        cha_q <= `RST_CHANNEL;
        ch3_q <= `RST_CHANNEL;
        ch4_q <= `RST_CHANNEL;
        ch5_q <= `RST_CHANNEL;
        ch6_q <= `RST_CHANNEL;
      end else if (reg_wr) begin
        case (reg_addr)
          `ADDR_GENERAL: general_q <= reg_wdata;
          `ADDR_CONFIG: config_q <= reg_wdata;
          `ADDR_CHA: cha_q <= reg_wdata;
          `ADDR_CH3: ch3_q <= reg_wdata;
          `ADDR_CH4: ch4_q <= reg_wdata;
          `ADDR_CH5: ch5_q <= reg_wdata;
          `ADDR_CH6: ch6_q <= reg_wdata;
          default: begin
            // Unmapped writes are dropped.
          end
        endcase
      end
    end
  end

  // Read data is registered; unmapped addresses read zero, a cleared device gives no answer.
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata_q <= `RD_UNMAPPED;
      reg_rvalid_q <= 1'b0;
      serial_enable_q <= 1'b0;
    end else if (ce) begin
      serial_enable_q <= !dev_clear;
      reg_rvalid_q <= reg_rd && !dev_clear;
      if (reg_rd && !dev_clear) begin
        case (reg_addr)
          `ADDR_GENERAL: reg_rdata_q <= general_q;
          `ADDR_CONFIG: reg_rdata_q <= config_q;
          `ADDR_CHA: reg_rdata_q <= cha_q;
          `ADDR_CH3: reg_rdata_q <= ch3_q;
          `ADDR_CH4: reg_rdata_q <= ch4_q;
          `ADDR_CH5: reg_rdata_q <= ch5_q;
          `ADDR_CH6: reg_rdata_q <= ch6_q;
          default: reg_rdata_q <= `RD_UNMAPPED;
        endcase
      end
    end
  end

  // ==========================================================================
  // Grouping and LED drive
  // ==========================================================================
  wire [3:0] join_a = config_q[`CFG_JOIN_HI:`CFG_JOIN_LO]; // LED3..LED6 join group A.
  wire [3:0] own_en = general_q[`GEN_EN_HI:`GEN_EN_LO]; // LED3..LED6 own enables.
  wire en_a = general_q[`GEN_EN_A_BIT]; // Group A enable.
  wire [CODE_W-1:0] code_a = cha_q[`CODE_HI:`CODE_LO];
  wire [4*CODE_W-1:0] own_code = {ch6_q[`CODE_HI:`CODE_LO], ch5_q[`CODE_HI:`CODE_LO],
                                  ch4_q[`CODE_HI:`CODE_LO], ch3_q[`CODE_HI:`CODE_LO]};
  // In dimming mode the pin gates current; in enable mode it is high here.
  wire gate = pwm_mode ? pin_q : 1'b1;
  reg [NUM_LED-1:0] led_on_d; // Next LED on pattern.
  reg [NUM_LED*CODE_W-1:0] led_code_d; // Next per-LED code.
  integer k;

  // The first two LEDs are always group A; the rest follow their join bit.
  always @* begin
    led_on_d = {NUM_LED{1'b0}};
    led_code_d = {NUM_LED*CODE_W{1'b0}};
    for (k = 0; k < NUM_LED; k = k + 1) begin
      if (k < 2 || join_a[(k-2)&3]) begin
        led_on_d[k] = en_a & gate & !dev_clear;
        led_code_d[k*CODE_W +: CODE_W] = code_a;
      end else begin
        led_on_d[k] = own_en[(k-2)&3] & gate & !dev_clear;
        led_code_d[k*CODE_W +: CODE_W] = own_code[((k-2)&3)*CODE_W +: CODE_W];
      end
    end
  end

  // Drive outputs come from flops so the analog side sees clean levels.
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      led_on_q <= {NUM_LED{1'b0}};
      led_code_q <= {NUM_LED*CODE_W{1'b1}};
    end else if (ce) begin
      led_on_q <= led_on_d;
      led_code_q <= led_code_d;
    end
  end

  // One lookup per LED; the level trails the code by one cycle.
  genvar g;
  generate
    for (g = 0; g < NUM_LED; g = g + 1) begin : g_lut
      led_level_lut #(.CODE_W(CODE_W)) u_lut (
        .clk(clk),
        .rst_sync_b(rst_sync_b),
        .ce(ce),
        .dimming_code_bits(led_code_q[g*CODE_W +: CODE_W]),
        .level_q(led_level[g*`LEVEL_W +: `LEVEL_W])
      );
    end
  endgenerate

  // ==========================================================================
  // Charge pump mode
  // ==========================================================================
  // Any active LED losing regulation means the highest-voltage one has.
  wire any_lost = |(lost_q & led_on_q);
  // The lowest active cathode is above threshold when every active one is.
  wire all_above = (|led_on_q) && (&(abv_q | ~led_on_q));
  reg pump_mode_d;

  // Two states; with no active LED the pump drops back to bypass.
  always @* begin
    case (pump_mode_q)
      `PUMP_1X: pump_mode_d = any_lost ? `PUMP_15X : `PUMP_1X;
      `PUMP_15X: pump_mode_d = (all_above || !(|led_on_q)) ? `PUMP_1X : `PUMP_15X;
      default: pump_mode_d = `PUMP_1X;
    endcase
  end

  // A cleared device always restarts in bypass.
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pump_mode_q <= `PUMP_1X;
    end else if (ce) begin
      pump_mode_q <= dev_clear ? `PUMP_1X : pump_mode_d;
    end
  end

endmodule // led_bank_ctrl
`default_nettype wire

// [testbench/led_bank_ctrl_asserts.sv]
/* Port checker of the LED bank control: read answers, clearing and pump mode.
   Assumes binding to led_bank_ctrl and the comparator flags held steady for cycles. */
`timescale 1ns/1ps
`default_nettype none
module led_bank_ctrl_chk #(
  parameter NUM_LED = 6,
  parameter CODE_W = 6
) (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Register port.
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata_q,
  input wire reg_rvalid_q,
  input wire serial_enable_q,
  // Comparators and drive.
  input wire [NUM_LED-1:0] reg_lost,
  input wire [NUM_LED-1:0] cathode_above,
  input wire [NUM_LED-1:0] led_on_q,
  input wire [NUM_LED*CODE_W-1:0] led_code_q,
  input wire pump_mode_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // Register answers
  // ====================
  property p_rv_cause; reg_rvalid_q |-> $past(reg_rd); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("answer without strobe");
  property p_rv_one; reg_rvalid_q && !reg_rd |=> !reg_rvalid_q; endproperty
  a_rv_one: assert property (p_rv_one) else $error("answer longer than a cycle");
  // An unmapped place still answers, with zero.
  property p_unmap; serial_enable_q && reg_rd && reg_addr == 8'h70 |=>
    reg_rvalid_q && reg_rdata_q == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  // ====================
  // Cleared device
  // ====================
  // Two cycles cleared give the pipeline time to land.
  property p_clr_off; !serial_enable_q [*2] |-> led_on_q == 0 && !pump_mode_q; endproperty
  a_clr_off: assert property (p_clr_off) else $error("drive left on while cleared");
  property p_clr_code; !serial_enable_q [*2] |-> &led_code_q; endproperty
  a_clr_code: assert property (p_clr_code) else $error("codes not default");
  // ====================
  // Pump mode
  // ====================
  // Eight cycles exceed the comparator synchroniser and filter.
  sequence s_lost; (|(led_on_q & reg_lost) && cathode_above == 0) [*8]; endsequence
  sequence s_quiet; (reg_lost == 0) [*8]; endsequence
  sequence s_high; (reg_lost == 0 && (led_on_q & ~cathode_above) == 0) [*8]; endsequence
  property p_up; s_lost |-> pump_mode_q; endproperty
  a_up: assert property (p_up) else $error("pump stayed 1x");
  property p_stay; s_quiet |-> !$rose(pump_mode_q); endproperty
  a_stay: assert property (p_stay) else $error("pump left 1x unprompted");
  property p_down; s_high |-> !pump_mode_q; endproperty
  a_down: assert property (p_down) else $error("pump stayed 1.5x");
endmodule // led_bank_ctrl_chk
bind led_bank_ctrl led_bank_ctrl_chk #(.NUM_LED(NUM_LED), .CODE_W(CODE_W)) led_bank_ctrl_chk_inst (
  .clk, .rst_b, .reg_rd, .reg_addr, .reg_rdata_q, .reg_rvalid_q, .serial_enable_q,
  .reg_lost, .cathode_above, .led_on_q, .led_code_q, .pump_mode_q);
`default_nettype wire

// [testbench/reg_host_model.sv]
/* Serial front end model: issues one-cycle write and read strobes.
   Assumes the block answers a read on the edge that takes it. */
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  // Clock.
  input wire clk,
  // Strobes towards the block.
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  // Read answer.
  input wire [7:0] reg_rdata_q,
  input wire reg_rvalid_q
);
  // ====================
  // Transfers
  // ====================
  // Idle bus shows inverted values so stale data cannot pass as fresh.
  initial begin
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h5A;
    reg_wdata = 8'hA5;
  end
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_q;
    v = reg_rvalid_q;
  endtask
endmodule // reg_host_model
`default_nettype wire

// [testbench/led_bank_ctrl_test.sv]
/* Self-checking bench of the LED bank control.
   Assumes the host model drives the register port; the bench drives pin and flags. */
`timescale 1ns/1ps
`default_nettype none
module led_bank_ctrl_test;
  // Driven inputs and observed outputs.
  logic clk, rst_b, ce, en_pin;
  logic [5:0] reg_lost, cathode_above;
  wire reg_wr, reg_rd, reg_rvalid_q, serial_enable_q, pump_mode_q;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire [5:0] led_on_q;
  wire [35:0] led_code_q;
  wire [101:0] led_level;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  led_bank_ctrl #(.NUM_LED(6), .CODE_W(6)) led_bank_ctrl_inst (.clk, .rst_b, .ce, .en_pin,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .serial_enable_q,
    .reg_lost, .cathode_above, .led_on_q, .led_code_q, .led_level, .pump_mode_q);
  reg_host_model reg_host_model_inst (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .reg_rvalid_q);
  // ====================
  // Clock, timeout, helpers
  // ====================
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Four edges cover register, drive and level stages.
  task automatic wr(input logic [7:0] a, d);
    reg_host_model_inst.wr(a, d);
    wt(4);
  endtask
  task automatic rdchk(input logic [7:0] a, exp);
    logic [7:0] d;
    logic v;
    reg_host_model_inst.rd(a, d, v);
    chk("rvalid", 1, v);
    chk("rdata", exp, d);
  endtask
  // Eight cycles cover the pin synchroniser and filter.
  task automatic pin(input logic v);
    @(posedge clk);
    en_pin <= v;
    wt(8);
  endtask
  task automatic drv(input logic [5:0] l, c);
    @(posedge clk);
    reg_lost <= l;
    cathode_above <= c;
    wt(12);
  endtask
  // ====================
  // Scenarios
  // ====================
  task automatic t_reset();
    chk("serial", 0, serial_enable_q);
    chk("code", 36'hFFFFFFFFF, led_code_q);
    pin(1);
    chk("serial", 1, serial_enable_q);
    rdchk(8'h10, 8'h00);
    rdchk(8'h20, 8'h00);
    rdchk(8'h60, 8'hFF);
    rdchk(8'h70, 8'h00);
    // A one-cycle dip on the pin must not reach the clearing logic.
    wr(8'h10, 8'h20);
    @(posedge clk);
    en_pin <= 1'b0;
    @(posedge clk);
    en_pin <= 1'b1;
    wt(8);
    rdchk(8'h10, 8'h20);
  endtask
  task automatic t_group();
    wr(8'h10, 8'h01);
    chk("on", 6'h03, led_on_q);
    wr(8'hA0, 8'h05);
    wr(8'h30, 8'h0A);
    chk("code", {{3{6'h3F}}, 6'h0A, {2{6'h05}}}, led_code_q);
    for (int i = 1; i < 5; i++) begin
      wr(8'h10, 8'h01 << i);
      chk("on", 6'h02 << i, led_on_q);
    end
    wr(8'h20, 8'h0F);
    wr(8'h10, 8'h01);
    chk("code", {6{6'h05}}, led_code_q);
    chk("on", 6'h3F, led_on_q);
    wr(8'h20, 8'h00);
    chk("on", 6'h03, led_on_q);
  endtask
  task automatic t_levels();
    logic [16:0] prev;
    prev = 0;
    for (int k = 0; k < 64; k++) begin
      wr(8'hA0, k[7:0]);
      chk("rise", 1, led_level[16:0] > prev);
      prev = led_level[16:0];
      if (k == 0) begin
        chk("lowest", 17'h0007D, prev);
      end
    end
    chk("full", 17'h186A0, prev);
    chk("pair", 17'h186A0, led_level[33:17]);
  endtask
  task automatic t_pwm();
    wr(8'h10, 8'h81);
    pin(0);
    chk("on", 0, led_on_q);
    chk("serial", 1, serial_enable_q);
    wr(8'hA0, 8'h2A);
    rdchk(8'hA0, 8'h2A);
    pin(1);
    chk("on", 6'h03, led_on_q);
    // Dimming burst at the 40 ns link rate.
    repeat (16) begin
      @(posedge clk);
      en_pin <= ~en_pin;
      // Five edges after a toggle the drive shows the level set before it.
      #1;
      chk("on", en_pin ? 6'h00 : 6'h03, led_on_q);
      repeat (4) @(posedge clk);
    end
    wt(8);
    chk("on", 6'h03, led_on_q);
    rdchk(8'h10, 8'h81);
    pin(0);
    wr(8'h10, 8'h01);
    chk("serial", 0, serial_enable_q);
    pin(1);
    rdchk(8'hA0, 8'hFF);
  endtask
  task automatic t_pump();
    wr(8'h10, 8'h01);
    drv(6'h02, 6'h00);
    chk("pump", 1, pump_mode_q);
    drv(6'h00, 6'h01);
    chk("pump", 1, pump_mode_q);
    drv(6'h00, 6'h03);
    chk("pump", 0, pump_mode_q);
    drv(6'h04, 6'h03);
    chk("pump", 0, pump_mode_q);
    drv(6'h00, 6'h00);
  endtask
  task automatic t_clear();
    logic [7:0] d;
    logic v;
    wr(8'hA0, 8'h11);
    pin(0);
    chk("serial", 0, serial_enable_q);
    chk("on", 0, led_on_q);
    reg_host_model_inst.rd(8'hA0, d, v);
    chk("refused", 0, v);
    reg_host_model_inst.wr(8'h20, 8'h0F);
    pin(1);
    rdchk(8'hA0, 8'hFF);
    rdchk(8'h20, 8'h00);
  endtask
  initial begin
    rst_b = 0;
    ce = 1;
    en_pin = 0;
    reg_lost = 0;
    cathode_above = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1;
    wt(4);
    t_reset();
    t_group();
    t_levels();
    t_pwm();
    t_pump();
    t_clear();
    test_done();
  end
endmodule // led_bank_ctrl_test
`default_nettype wire
